/* File: rtl/snr_regs.svh */
// Constants for the serial nvram read path.
// Assumes a 10 MHz system clock and a 100 kHz bus clock.
`ifndef SNR_REGS_SVH
`define SNR_REGS_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define SNR_CLK_NS 100
`define SNR_SCL_HALF_NS 5000
`define SNR_QTR_CYC (((`SNR_SCL_HALF_NS / 2) + `SNR_CLK_NS - 1) / `SNR_CLK_NS)
// ----------------------------------------
// Slave address byte
// ----------------------------------------
// Device type value is arbitrary
`define SNR_DEV_TYPE 4'h6
`define SNR_RW_READ 1'b1
`define SNR_RW_WRITE 1'b0
`define SNR_ADDR_W 9
`define SNR_MEM_DEPTH 512
// ----------------------------------------
// Bit counts
// ----------------------------------------
`define SNR_LAST_DBIT 4'h7
`define SNR_ACK_BIT 4'h8
// ----------------------------------------
// Read end methods
// ----------------------------------------
`define SNR_END_NACK_STOP 2'h0
`define SNR_END_NACK_START 2'h1
`define SNR_END_STOP9 2'h2
`define SNR_END_START9 2'h3
// ----------------------------------------
// Host byte sequence
// ----------------------------------------
`define SNR_SEQ_WADDR 3'h0
`define SNR_SEQ_WORD 3'h1
`define SNR_SEQ_RST 3'h2
`define SNR_SEQ_RADDR 3'h3
`define SNR_SEQ_DATA 3'h4
`endif

/* File: rtl/snr_pkg.sv */
// Types shared by both ends of the serial nvram read path.
// Assumes nothing of its surroundings.
package snr_pkg;
  // ----------------------------------------
  // State types
  // ----------------------------------------
  typedef enum logic [3:0] {
    D_IDLE = 4'h0,
    D_ADDR = 4'h1,
    D_ADDR_ACK = 4'h3,
    D_RD = 4'h2,
    D_RD_ACK = 4'h6,
    D_WORD = 4'h7,
    D_WORD_ACK = 4'h5
  } snr_dev_state_t;
  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_START = 3'h1,
    H_SEND = 3'h3,
    H_RECV = 3'h2,
    H_STOP = 3'h6,
    H_WAIT = 3'h7
  } snr_host_state_t;
endpackage : snr_pkg

/* File: rtl/snr_link_if.sv */
// Two-wire link between the bus master and the memory slave.
// Assumes open-drain wires with pull-ups; an enable pulls low.
`timescale 1ns/1ps
interface snr_link_if;
  logic h_scl_o;
  logic h_scl_oe;
  logic h_sda_o;
  logic h_sda_oe;
  logic d_sda_o;
  logic d_sda_oe;
  logic scl;
  logic sda;
  // ----------------------------------------
  // Wire resolution
  // ----------------------------------------
  assign scl = ~(h_scl_oe & ~h_scl_o);
  assign sda = ~((h_sda_oe & ~h_sda_o) | (d_sda_oe & ~d_sda_o));
  modport host (output h_scl_o, output h_scl_oe, output h_sda_o, output h_sda_oe, input scl, input sda);
  modport dev (output d_sda_o, output d_sda_oe, input scl, input sda);
endinterface : snr_link_if

/* File: rtl/snr_dev.sv */
// Memory slave end: 512-byte store with the two-wire read path.
// Assumes the link interface, and bus pins asynchronous to sys_clk_i.
// ----------------------------------------
// Overview of operation
// - Current read takes low bits from latch
// - Current read continues after last access
// - Master sets direction bit one to read
// - Page bit sits above latched low bits
// - Data driven MSB first after address ack
// - Address counter increments after each byte
// - Master ack requests the next byte
// - Master ends: no-ack, then stop
// - Master ends: no-ack, then start
// - Stop in ack clock ends read
// - Start in ack clock restarts addressing
// - Unended read keeps driving data
// - Address wraps from top to zero
// - Selective read opens with write address
// - Word address loads latch and is acked
// - Restart aborts write, memory untouched
// - Respond only when select bits match pins
// - Master no-ack ends the read
// ----------------------------------------
`timescale 1ns/1ps
`include "snr_regs.svh"
module snr_dev
  import snr_pkg::*;
#(
  parameter int ADDR_W = `SNR_ADDR_W,
  parameter int DEPTH = `SNR_MEM_DEPTH,
  parameter logic [3:0] DEV_TYPE = `SNR_DEV_TYPE
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Link
  snr_link_if.dev lnk,
  // Device select pins
  input wire logic [1:0] device_select_pins_i,
  // Preload port
  input wire logic load_en_i,
  input wire logic [ADDR_W-1:0] load_addr_i,
  input wire logic [7:0] load_data_i,
  // Status
  output logic busy_o,
  output logic [ADDR_W-1:0] cur_addr_o
);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  if (ADDR_W != 9 || DEPTH != (1 << ADDR_W)) begin : g_bad_size
    $error("snr_dev: page bit plus eight latched bits need a 512-byte store");
  end

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic scl_m_r;
  logic scl_s_r;
  logic scl_p_r;
  logic sda_m_r;
  logic sda_s_r;
  logic sda_p_r;
  logic [1:0] sel_m_r;
  logic [1:0] sel_s_r;
  snr_dev_state_t st_r;
  snr_dev_state_t st_nxt;
  logic [3:0] bcnt_r;
  logic [3:0] bcnt_nxt;
  logic [7:0] sh_r;
  logic [7:0] sh_nxt;
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] addr_nxt;
  logic page_r;
  logic page_nxt;
  logic rd_r;
  logic rd_nxt;
  logic ack_r;
  logic ack_nxt;
  logic oe_r;
  logic oe_nxt;
  logic busy_r;
  logic busy_nxt;
  logic [7:0] mem [DEPTH];
  logic [ADDR_W-1:0] rd_idx;
  logic [7:0] rd_byte;
  logic start_ev;
  logic stop_ev;
  logic rise_ev;
  logic fall_ev;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_p_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_p_r <= 1'b1;
      sel_m_r <= 2'h0;
      sel_s_r <= 2'h0;
    end else begin
      scl_m_r <= lnk.scl;
      scl_s_r <= scl_m_r;
      scl_p_r <= scl_s_r;
      sda_m_r <= lnk.sda;
      sda_s_r <= sda_m_r;
      sda_p_r <= sda_s_r;
      sel_m_r <= device_select_pins_i;
      sel_s_r <= sel_m_r;
    end
  end

  assign start_ev = scl_s_r & scl_p_r & sda_p_r & ~sda_s_r;
  assign stop_ev = scl_s_r & scl_p_r & ~sda_p_r & sda_s_r;
  assign rise_ev = scl_s_r & ~scl_p_r;
  assign fall_ev = ~scl_s_r & scl_p_r;

  // ----------------------------------------
  // Memory read port
  // ----------------------------------------
  assign rd_idx = (st_r == D_ADDR_ACK) ? {page_r, addr_r[7:0]} : addr_r;
  assign rd_byte = mem[rd_idx];

  // ----------------------------------------
  // Protocol next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    bcnt_nxt = bcnt_r;
    sh_nxt = sh_r;
    addr_nxt = addr_r;
    page_nxt = page_r;
    rd_nxt = rd_r;
    ack_nxt = ack_r;
    oe_nxt = oe_r;
    if (stop_ev) begin
      st_nxt = D_IDLE;
      oe_nxt = 1'b0;
    end else if (start_ev) begin
      st_nxt = D_ADDR;
      bcnt_nxt = 4'h0;
      oe_nxt = 1'b0;
    end else begin
      case (st_r)
        D_IDLE: begin
          oe_nxt = 1'b0;
        end
        D_ADDR, D_WORD: begin
          if (rise_ev && bcnt_r != `SNR_ACK_BIT) begin
            sh_nxt = {sh_r[6:0], sda_s_r};
            bcnt_nxt = bcnt_r + 4'h1;
          end else if (fall_ev && bcnt_r == `SNR_ACK_BIT) begin
            if (st_r == D_WORD) begin
              addr_nxt = {page_r, sh_r};
              oe_nxt = 1'b1;
              st_nxt = D_WORD_ACK;
            end else if (sh_r[7:4] == DEV_TYPE && sh_r[3:2] == sel_s_r) begin
              page_nxt = sh_r[1];
              rd_nxt = (sh_r[0] == `SNR_RW_READ);
              oe_nxt = 1'b1;
              st_nxt = D_ADDR_ACK;
            end else begin
              st_nxt = D_IDLE;
            end
          end
        end
        D_ADDR_ACK: begin
          if (fall_ev) begin
            bcnt_nxt = 4'h0;
            if (rd_r) begin
              addr_nxt = rd_idx;
              sh_nxt = rd_byte;
              oe_nxt = ~rd_byte[7];
              st_nxt = D_RD;
            end else begin
              oe_nxt = 1'b0;
              st_nxt = D_WORD;
            end
          end
        end
        D_WORD_ACK: begin
          if (fall_ev) begin
            oe_nxt = 1'b0;
            st_nxt = D_IDLE;
          end
        end
        D_RD: begin
          if (fall_ev) begin
            if (bcnt_r == `SNR_LAST_DBIT) begin
              oe_nxt = 1'b0;
              addr_nxt = addr_r + 9'h001;
              ack_nxt = 1'b0;
              st_nxt = D_RD_ACK;
            end else begin
              sh_nxt = {sh_r[6:0], 1'b0};
              oe_nxt = ~sh_r[6];
              bcnt_nxt = bcnt_r + 4'h1;
            end
          end
        end
        D_RD_ACK: begin
          if (rise_ev) begin
            ack_nxt = ~sda_s_r;
          end else if (fall_ev) begin
            if (ack_r) begin
              sh_nxt = rd_byte;
              oe_nxt = ~rd_byte[7];
              bcnt_nxt = 4'h0;
              st_nxt = D_RD;
            end else begin
              st_nxt = D_IDLE;
            end
          end
        end
        default: begin
          st_nxt = D_IDLE;
          oe_nxt = 1'b0;
        end
      endcase
    end
    busy_nxt = (st_nxt != D_IDLE);
  end

  // ----------------------------------------
  // Protocol registers
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= D_IDLE;
      bcnt_r <= 4'h0;
      sh_r <= 8'h00;
      addr_r <= 9'h000;
      page_r <= 1'b0;
      rd_r <= 1'b0;
      ack_r <= 1'b0;
      oe_r <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      bcnt_r <= bcnt_nxt;
      sh_r <= sh_nxt;
      addr_r <= addr_nxt;
      page_r <= page_nxt;
      rd_r <= rd_nxt;
      ack_r <= ack_nxt;
      oe_r <= oe_nxt;
      busy_r <= busy_nxt;
    end
  end

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (load_en_i) begin
      mem[load_addr_i] <= load_data_i;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign lnk.d_sda_o = 1'b0;
  assign lnk.d_sda_oe = oe_r;
  assign busy_o = busy_r;
  assign cur_addr_o = addr_r;
endmodule : snr_dev

/* File: rtl/snr_host.sv */
// Bus master end: issues current and selective reads, buffers bytes.
// Assumes the link interface and a slave on the same wires.
`timescale 1ns/1ps
`include "snr_regs.svh"
module snr_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("snr_fifo: depth must be a power of two, at least two");
  end
  logic [W-1:0] buf_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [CW-1:0] cnt_r;
  logic push;
  logic pop;
  assign in_ready_o = (cnt_r != CW'(DEPTH));
  assign out_valid_o = (cnt_r != '0);
  assign out_data_o = buf_r[rp_r];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= push ? wp_r + AW'(1) : wp_r;
      rp_r <= pop ? rp_r + AW'(1) : rp_r;
      cnt_r <= cnt_r + CW'(push) - CW'(pop);
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (push) begin
      buf_r[wp_r] <= in_data_i;
    end
  end
endmodule : snr_fifo

module snr_host
  import snr_pkg::*;
#(
  parameter int QTR_CYC = `SNR_QTR_CYC,
  parameter int BUF_DEPTH = 2,
  parameter logic [3:0] DEV_TYPE = `SNR_DEV_TYPE
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Link
  snr_link_if.host lnk,
  // Command
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic cmd_sel_i,
  input wire logic [1:0] cmd_dsel_i,
  input wire logic cmd_page_i,
  input wire logic [7:0] cmd_addr_i,
  input wire logic [7:0] cmd_len_i,
  input wire logic [1:0] cmd_end_i,
  // Read data
  output logic rd_valid_o,
  input wire logic rd_ready_i,
  output logic [7:0] rd_data_o,
  // Status
  output logic done_o,
  output logic nack_o
);
  if (QTR_CYC < 2 || QTR_CYC > 255) begin : g_bad_qtr
    $error("snr_host: quarter period out of range");
  end
  localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);
  snr_host_state_t st_r, st_nxt;
  logic [7:0] q_r, q_nxt, tx_r, tx_nxt, rx_r, rx_nxt, cnt_r, cnt_nxt, wa_r, wa_nxt;
  logic [1:0] ph_r, ph_nxt, end_r, end_nxt, ds_r, ds_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [2:0] seq_r, seq_nxt;
  logic pg_r, pg_nxt, term_r, term_nxt, push_r, push_nxt, done_r, done_nxt;
  logic nack_r, nack_nxt, rdy_r, rdy_nxt, sclo_r, sclo_nxt, sdao_r, sdao_nxt;
  logic sda_m_r, sda_s_r, tick, fifo_rdy, last;

  // ----------------------------------------
  // Data buffer and pin synchroniser
  // ----------------------------------------
  snr_fifo #(.W(8), .DEPTH(BUF_DEPTH)) u_buf (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .in_valid_i(push_r), .in_ready_o(fifo_rdy), .in_data_i(rx_r),
    .out_valid_o(rd_valid_o), .out_ready_i(rd_ready_i), .out_data_o(rd_data_o)
  );
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
    end else begin
      sda_m_r <= lnk.sda;
      sda_s_r <= sda_m_r;
    end
  end
  assign tick = (q_r == QTR_LAST);
  assign last = (cnt_r <= 8'h01);

  // ----------------------------------------
  // Sequencer next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    {q_nxt, ph_nxt, bit_nxt, tx_nxt, rx_nxt, cnt_nxt} = {q_r, ph_r, bit_r, tx_r, rx_r, cnt_r};
    {seq_nxt, wa_nxt, end_nxt, ds_nxt, pg_nxt, term_nxt} = {seq_r, wa_r, end_r, ds_r, pg_r, term_r};
    {push_nxt, done_nxt, nack_nxt} = {1'b0, 1'b0, nack_r};
    if (st_r != H_IDLE && st_r != H_WAIT) begin
      q_nxt = tick ? 8'h00 : q_r + 8'h01;
    end
    case (st_r)
      H_IDLE: begin
        if (cmd_valid_i && rdy_r) begin
          {ds_nxt, pg_nxt, wa_nxt, cnt_nxt, end_nxt} = {cmd_dsel_i, cmd_page_i, cmd_addr_i, cmd_len_i, cmd_end_i};
          seq_nxt = cmd_sel_i ? `SNR_SEQ_WADDR : `SNR_SEQ_RADDR;
          st_nxt = H_START;
          {q_nxt, ph_nxt, term_nxt, nack_nxt} = {8'h00, 2'h0, 1'b0, 1'b0};
        end
      end
      H_WAIT: begin
        if (fifo_rdy) begin
          st_nxt = H_RECV;
          {q_nxt, ph_nxt} = {8'h00, 2'h0};
        end
      end
      default: begin
        if (tick) begin
          ph_nxt = ph_r + 2'h1;
          if (ph_r == 2'h3) begin
            bit_nxt = bit_r + 4'h1;
            case (st_r)
              H_START: begin
                bit_nxt = 4'h0;
                st_nxt = term_r ? H_STOP : H_SEND;
                term_nxt = 1'b0;
                if (seq_r == `SNR_SEQ_RST) begin
                  seq_nxt = `SNR_SEQ_RADDR;
                end
                tx_nxt = {DEV_TYPE, ds_r, pg_r, (seq_r == `SNR_SEQ_WADDR) ? `SNR_RW_WRITE : `SNR_RW_READ};
              end
              H_SEND: begin
                if (bit_r == `SNR_ACK_BIT) begin
                  bit_nxt = 4'h0;
                  if (sda_s_r) begin
                    nack_nxt = 1'b1;
                    st_nxt = H_STOP;
                  end else if (seq_r == `SNR_SEQ_WADDR) begin
                    {seq_nxt, tx_nxt} = {`SNR_SEQ_WORD, wa_r};
                  end else if (seq_r == `SNR_SEQ_WORD) begin
                    seq_nxt = `SNR_SEQ_RST;
                    st_nxt = H_START;
                  end else begin
                    seq_nxt = `SNR_SEQ_DATA;
                    st_nxt = fifo_rdy ? H_RECV : H_WAIT;
                  end
                end
              end
              H_RECV: begin
                if (bit_r == `SNR_LAST_DBIT) begin
                  push_nxt = 1'b1;
                end else if (bit_r == `SNR_ACK_BIT) begin
                  bit_nxt = 4'h0;
                  if (!last) begin
                    cnt_nxt = cnt_r - 8'h01;
                    st_nxt = fifo_rdy ? H_RECV : H_WAIT;
                  end else if (end_r == `SNR_END_STOP9) begin
                    st_nxt = H_IDLE;
                    done_nxt = 1'b1;
                  end else if (end_r == `SNR_END_NACK_START) begin
                    st_nxt = H_START;
                    term_nxt = 1'b1;
                  end else begin
                    st_nxt = H_STOP;
                  end
                end
              end
              default: begin
                st_nxt = H_IDLE;
                done_nxt = 1'b1;
              end
            endcase
          end else if (ph_r == 2'h2 && st_r == H_RECV && bit_r != `SNR_ACK_BIT) begin
            rx_nxt = {rx_r[6:0], sda_s_r};
          end
        end
      end
    endcase
    rdy_nxt = (st_nxt == H_IDLE);
    case (st_nxt)
      H_START: {sclo_nxt, sdao_nxt} = {ph_nxt == 2'h0 || ph_nxt == 2'h3, ph_nxt[1]};
      H_STOP: {sclo_nxt, sdao_nxt} = {ph_nxt == 2'h0, ph_nxt != 2'h3};
      H_SEND: {sclo_nxt, sdao_nxt} = {~ph_nxt[1], bit_nxt != `SNR_ACK_BIT && !tx_nxt[3'h7 - bit_nxt[2:0]]};
      H_RECV: begin
        sclo_nxt = ~ph_nxt[1];
        sdao_nxt = 1'b0;
        if (bit_nxt == `SNR_ACK_BIT) begin
          if (!last) begin
            sdao_nxt = 1'b1;
          end else if (end_r == `SNR_END_STOP9) begin
            sdao_nxt = (ph_nxt != 2'h3);
          end else if (end_r == `SNR_END_START9) begin
            sdao_nxt = (ph_nxt == 2'h3);
          end
        end
      end
      H_WAIT: {sclo_nxt, sdao_nxt} = {1'b1, 1'b0};
      default: {sclo_nxt, sdao_nxt} = {1'b0, 1'b0};
    endcase
  end

  // ----------------------------------------
  // Sequencer registers
  // ----------------------------------------
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_r <= H_IDLE;
      {q_r, ph_r, bit_r, tx_r, rx_r, cnt_r} <= {8'h00, 2'h0, 4'h0, 8'h00, 8'h00, 8'h00};
      {seq_r, wa_r, end_r, ds_r, pg_r, term_r} <= {3'h0, 8'h00, 2'h0, 2'h0, 1'b0, 1'b0};
      {push_r, done_r, nack_r, rdy_r, sclo_r, sdao_r} <= {1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    end else begin
      st_r <= st_nxt;
      {q_r, ph_r, bit_r, tx_r, rx_r, cnt_r} <= {q_nxt, ph_nxt, bit_nxt, tx_nxt, rx_nxt, cnt_nxt};
      {seq_r, wa_r, end_r, ds_r, pg_r, term_r} <= {seq_nxt, wa_nxt, end_nxt, ds_nxt, pg_nxt, term_nxt};
      {push_r, done_r, nack_r, rdy_r, sclo_r, sdao_r} <= {push_nxt, done_nxt, nack_nxt, rdy_nxt, sclo_nxt, sdao_nxt};
    end
  end
  assign lnk.h_scl_o = 1'b0;
  assign lnk.h_scl_oe = sclo_r;
  assign lnk.h_sda_o = 1'b0;
  assign lnk.h_sda_oe = sdao_r;
  assign cmd_ready_o = rdy_r;
  assign done_o = done_r;
  assign nack_o = nack_r;
endmodule : snr_host

/* File: tb/snr_props.sv */
// Checker of the two-wire link between the two ends.
// Assumes the link signals are wired in by name.
`timescale 1ns/1ps
module snr_props (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Link
  input wire logic h_scl_o,
  input wire logic h_scl_oe,
  input wire logic h_sda_o,
  input wire logic h_sda_oe,
  input wire logic d_sda_o,
  input wire logic d_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_r, sda_r, first_r, rd_r, first_nxt, rd_nxt, rise, start_c, stop_c;
  logic [3:0] bit_r, bit_nxt;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  // ----------------------------------------
  // Framing tracker
  // ----------------------------------------
  always_comb begin
    rise = scl && !scl_r;
    start_c = scl && scl_r && sda_r && !sda;
    stop_c = scl && scl_r && !sda_r && sda;
    first_nxt = first_r;
    rd_nxt = rd_r;
    bit_nxt = bit_r;
    if (start_c || stop_c) begin
      first_nxt = start_c;
      rd_nxt = 1'b0;
      bit_nxt = 4'h0;
    end else if (rise) begin
      if (first_r && bit_r == 4'h7) begin
        rd_nxt = sda;
      end
      if (bit_r == 4'h8) begin
        first_nxt = 1'b0;
      end
      bit_nxt = (bit_r == 4'h8) ? 4'h0 : bit_r + 4'h1;
    end
  end
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
      first_r <= 1'b0;
      rd_r <= 1'b0;
      bit_r <= 4'h0;
    end else begin
      scl_r <= scl;
      sda_r <= sda;
      first_r <= first_nxt;
      rd_r <= rd_nxt;
      bit_r <= bit_nxt;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence ack_rise_s;
    rise && rd_r && !first_r && bit_r == 4'h8;
  endsequence
  chk_dev_od_level: assert property (d_sda_o == 1'b0)
    else $error("device drives a high level");
  chk_host_od_level: assert property (!h_scl_o && !h_sda_o)
    else $error("host drives a high level");
  chk_dev_edge_low: assert property ($changed(d_sda_oe) |-> !scl)
    else $error("device data changed while clock high");
  chk_ack_release: assert property (ack_rise_s |-> !d_sda_oe)
    else $error("device held data line in ack clock");
  chk_nack_quiet: assert property (ack_rise_s ##0 sda |=> !d_sda_oe [*8])
    else $error("device drove after no-ack");
  chk_stop_quiet: assert property (stop_c |-> !d_sda_oe [*8])
    else $error("device drove after stop");
  chk_addr_quiet: assert property (rise && first_r && bit_r < 4'h8 |-> !d_sda_oe)
    else $error("device drove during address bits");
  chk_host_frame: assert property (scl && scl_r && $changed(h_sda_oe) |-> start_c || stop_c || d_sda_oe)
    else $error("host moved data line while clock high");
  chk_read_dir_drive: assert property (rise && !first_r && bit_r < 4'h8 && d_sda_oe |-> rd_r)
    else $error("device drove data outside a read");
endmodule : snr_props

/* File: tb/tb.sv */
// Testbench: host end reads the memory end over the link.
// Assumes both ends and the link interface are compiled first.
`timescale 1ns/1ps
module tb;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [1:0] pins = 2'h1;
  logic load_en = 1'b0;
  logic [8:0] load_addr = 9'h000;
  logic [7:0] load_data = 8'h00;
  logic cmd_valid = 1'b0, cmd_sel = 1'b0, cmd_page = 1'b0, rd_ready = 1'b0;
  logic [1:0] cmd_dsel = 2'h0, cmd_end = 2'h0;
  logic [7:0] cmd_addr = 8'h00, cmd_len = 8'h00;
  logic busy, cmd_ready, rd_valid, done, nack;
  logic [7:0] rd_data;
  logic [8:0] cur_addr, model_addr = 9'h000;
  int n_errors = 0, tests_run = 0, cyc_cnt = 0;
  always #50 sys_clk_i = ~sys_clk_i;
  snr_link_if snr_link_if_inst ();
  snr_dev snr_dev_inst (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .lnk(snr_link_if_inst),
    .device_select_pins_i(pins), .load_en_i(load_en), .load_addr_i(load_addr), .load_data_i(load_data),
    .busy_o(busy), .cur_addr_o(cur_addr));
  snr_host #(.QTR_CYC(4)) snr_host_inst (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .lnk(snr_link_if_inst),
    .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_sel_i(cmd_sel), .cmd_dsel_i(cmd_dsel),
    .cmd_page_i(cmd_page), .cmd_addr_i(cmd_addr), .cmd_len_i(cmd_len), .cmd_end_i(cmd_end),
    .rd_valid_o(rd_valid), .rd_ready_i(rd_ready), .rd_data_o(rd_data), .done_o(done), .nack_o(nack));
  snr_props snr_props_inst (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .h_scl_o(snr_link_if_inst.h_scl_o), .h_scl_oe(snr_link_if_inst.h_scl_oe),
    .h_sda_o(snr_link_if_inst.h_sda_o), .h_sda_oe(snr_link_if_inst.h_sda_oe),
    .d_sda_o(snr_link_if_inst.d_sda_o), .d_sda_oe(snr_link_if_inst.d_sda_oe),
    .scl(snr_link_if_inst.scl), .sda(snr_link_if_inst.sda));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] mdata(input logic [8:0] a);
    return a[7:0] ^ (a[8] ? 8'hA5 : 8'h3C);
  endfunction : mdata
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check
  task automatic complete_run();
    if (n_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic run_cmd(input logic sel, input logic [1:0] dsel, input logic page, input logic [7:0] waddr,
      input logic [7:0] len, input logic [1:0] endm, input int stall, input logic exp_nack);
    logic [8:0] addr;
    int n;
    int want;
    logic seen;
    addr = sel ? {page, waddr} : {page, model_addr[7:0]};
    n = 0;
    seen = 1'b0;
    want = exp_nack ? 0 : ((len == 8'h00) ? 1 : int'(len));
    @(negedge sys_clk_i);
    while (cmd_ready !== 1'b1) @(negedge sys_clk_i);
    @(posedge sys_clk_i);
    cmd_valid <= 1'b1;
    cmd_sel <= sel;
    cmd_dsel <= dsel;
    cmd_page <= page;
    cmd_addr <= waddr;
    cmd_len <= len;
    cmd_end <= endm;
    rd_ready <= (stall == 0);
    @(posedge sys_clk_i);
    cmd_valid <= 1'b0;
    for (int c = 0; c >= 0; c++) begin
      @(negedge sys_clk_i);
      if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
        check({1'b0, rd_data}, {1'b0, mdata(addr)});
        if (n == 0) check({8'h00, busy}, 9'h001);
        addr = addr + 9'h001;
        n++;
      end
      if (done === 1'b1) seen = 1'b1;
      if (seen && rd_valid !== 1'b1) break;
      @(posedge sys_clk_i);
      rd_ready <= (c >= stall);
    end
    check(n[8:0], want[8:0]);
    check({8'h00, nack}, {8'h00, exp_nack});
    check({8'h00, busy}, 9'h000);
    if (!exp_nack) model_addr = (sel ? {page, waddr} : {page, model_addr[7:0]}) + want[8:0];
    check(cur_addr, model_addr);
  endtask : run_cmd
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  always @(posedge sys_clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 40000) begin
      n_errors++;
      complete_run();
    end
  end
  initial begin
    repeat (6) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 512; i++) begin
      @(posedge sys_clk_i);
      load_en <= 1'b1;
      load_addr <= i[8:0];
      load_data <= mdata(i[8:0]);
    end
    @(posedge sys_clk_i);
    load_en <= 1'b0;
    @(negedge sys_clk_i);
    check(cur_addr, 9'h000);
    run_cmd(1'b1, 2'h1, 1'b0, 8'h10, 8'h03, 2'h0, 0, 1'b0);
    run_cmd(1'b0, 2'h1, 1'b1, 8'h00, 8'h02, 2'h1, 0, 1'b0);
    run_cmd(1'b0, 2'h1, 1'b1, 8'h00, 8'h00, 2'h2, 0, 1'b0);
    run_cmd(1'b0, 2'h1, 1'b0, 8'h00, 8'h02, 2'h3, 0, 1'b0);
    run_cmd(1'b0, 2'h2, 1'b0, 8'h00, 8'h02, 2'h0, 0, 1'b1);
    run_cmd(1'b1, 2'h1, 1'b1, 8'hFE, 8'h04, 2'h0, 0, 1'b0);
    @(posedge sys_clk_i);
    pins <= 2'h2;
    run_cmd(1'b0, 2'h2, 1'b0, 8'h00, 8'h05, 2'h0, 1500, 1'b0);
    complete_run();
  end
endmodule : tb
